// file: verilog/baud_gen_pkg.sv
package baud_gen_pkg;

  // Register indices on the plain register port (8-bit data).
  localparam logic [7:0] RX_STATUS_CONTROL_ADDR = 8'h13;
  localparam logic [7:0] TX_STATUS_CONTROL_ADDR = 8'h15;
  localparam logic [7:0] BAUD_DIVISOR_ADDR      = 8'h17;

  // Field positions.
  localparam int CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int SYNC_MODE_BIT           = 4;
  localparam int PORT_ENABLE_BIT         = 7;

  // Values after reset of the control registers.
  localparam logic [7:0] TX_STATUS_CONTROL_RESET = 8'h02;
  localparam logic [7:0] RX_STATUS_CONTROL_RESET = 8'h00;
  // Power-on value of the divisor is undefined; zero is used.
  localparam logic [7:0] BAUD_DIVISOR_POWER_ON   = 8'h00;

  // Oscillator clocks per divisor step, less one, in each mode.
  localparam logic [5:0] ASYNC_PRESCALE = 6'h3f;
  localparam logic [5:0] SYNC_PRESCALE  = 6'h03;

  typedef enum logic [1:0] {
    MODE_ASYNC        = 2'b00,
    MODE_SYNC_MASTER  = 2'b01,
    MODE_SYNC_SLAVE   = 2'b10
  } rate_mode_e;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : baud_gen_pkg

// file: verilog/rate_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the oscillator by one more than a selectable modulus, restarts on clear.
module rate_prescaler
  import baud_gen_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Control
  input  wire logic       clear_in,
  input  wire logic [5:0] modulus_in,
  // Step pulse
  output logic            step_out
);

  logic [5:0] count;
  logic [5:0] next_count;
  logic       next_step;

  always_comb begin
    next_step  = 1'b0;
    next_count = count + 6'h01;
    if (clear_in) begin
      next_count = 6'h00;
    end else if (count >= modulus_in) begin
      next_count = 6'h00;
      next_step  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      count    <= 6'h00;
      step_out <= 1'b0;
    end else begin
      count    <= next_count;
      step_out <= next_step;
    end
  end

endmodule : rate_prescaler
`default_nettype wire

// file: verilog/usart_baud_rate_generator.sv
// Notes on behaviour
// [R1] Free-running 8-bit timer, period from divisor.
// [R2] Rate is osc/64(X+1) async, osc/4(X+1) sync.
// [R3] Divisor 0..255, every value legal.
// [R4] Rate used only async or sync master.
// [R5] One generator serves both modes.
// [R6] Divisor write clears the timer immediately.
// [R7] Divisor undefined at power-on, kept otherwise.
// [R8] Period end reloads and emits one-cycle tick.
`timescale 1ns/1ps
`default_nettype none
module usart_baud_rate_generator
  import baud_gen_pkg::*;
(
  // Clock and resets
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       power_on_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       write_in,
  input  wire logic       read_in,
  output logic      [7:0] rdata_out,
  // Shift logic timing
  output logic            tick_out,
  output logic            rate_active_out,
  output logic            sync_mode_out
);

  // Request carrier and decoded strobes.
  reg_req_s   req;
  logic       any_reset;
  logic       divisor_write;
  logic       tx_write;
  logic       rx_write;
  logic       divisor_read;
  logic       tx_read;
  logic       rx_read;

  // Software-visible registers.
  logic [7:0] baud_divisor;
  logic [7:0] tx_status_control;
  logic [7:0] rx_status_control;
  logic [7:0] next_baud_divisor;
  logic [7:0] next_tx_status_control;
  logic [7:0] next_rx_status_control;

  // Read path.
  logic [7:0] next_rdata;

  // Mode decode.
  rate_mode_e mode;
  logic       sync_mode;
  logic       clock_source_select;
  logic       next_rate_active;
  logic       next_sync_mode;

  // Prescaler and bit-rate timer.
  logic [5:0] modulus;
  logic       step;
  logic       timer_expired;
  logic [7:0] bit_rate_timer;
  logic [7:0] next_bit_rate_timer;
  logic       next_tick;

  assign any_reset = rst_in || power_on_in;
  assign req       = '{write: write_in, read: read_in, addr: addr_in, wdata: wdata_in};

  // Write decoding of the register port; unmapped indices are ignored.
  always_comb begin
    divisor_write = 1'h0;
    tx_write      = 1'h0;
    rx_write      = 1'h0;
    if (req.write) begin
      if (req.addr == BAUD_DIVISOR_ADDR) begin
        divisor_write = 1'h1;
      end else if (req.addr == TX_STATUS_CONTROL_ADDR) begin
        tx_write = 1'h1;
      end else if (req.addr == RX_STATUS_CONTROL_ADDR) begin
        rx_write = 1'h1;
      end
    end
  end

  // Read decoding of the register port.
  always_comb begin
    divisor_read = 1'h0;
    tx_read      = 1'h0;
    rx_read      = 1'h0;
    if (req.read) begin
      if (req.addr == BAUD_DIVISOR_ADDR) begin
        divisor_read = 1'h1;
      end else if (req.addr == TX_STATUS_CONTROL_ADDR) begin
        tx_read = 1'h1;
      end else if (req.addr == RX_STATUS_CONTROL_ADDR) begin
        rx_read = 1'h1;
      end
    end
  end

  // The divisor survives the ordinary reset; only power-on resets it.
  always_comb begin
    next_baud_divisor = baud_divisor;
    if (divisor_write) begin
      next_baud_divisor = req.wdata; // [R3]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (power_on_in) begin
      baud_divisor <= BAUD_DIVISOR_POWER_ON; // [R7]
    end else begin
      baud_divisor <= next_baud_divisor; // [R7]
    end
  end

  // Control registers return to their reset values on every reset.
  always_comb begin
    next_tx_status_control = tx_status_control;
    next_rx_status_control = rx_status_control;
    if (tx_write) begin
      next_tx_status_control = req.wdata;
    end
    if (rx_write) begin
      next_rx_status_control = req.wdata;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (any_reset) begin
      tx_status_control <= TX_STATUS_CONTROL_RESET;
      rx_status_control <= RX_STATUS_CONTROL_RESET;
    end else begin
      tx_status_control <= next_tx_status_control;
      rx_status_control <= next_rx_status_control;
    end
  end

  // Read data stand for one cycle only; idle and unmapped reads give zero.
  always_comb begin
    next_rdata = 8'h00;
    if (divisor_read) begin
      next_rdata = baud_divisor;
    end else if (tx_read) begin
      next_rdata = tx_status_control;
    end else if (rx_read) begin
      next_rdata = rx_status_control;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (any_reset) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // Mode decode from the transmit status and control register.
  assign sync_mode           = tx_status_control[SYNC_MODE_BIT];
  assign clock_source_select = tx_status_control[CLOCK_SOURCE_SELECT_BIT];

  always_comb begin
    if (!sync_mode) begin
      mode = MODE_ASYNC;
    end else if (clock_source_select) begin
      mode = MODE_SYNC_MASTER;
    end else begin
      mode = MODE_SYNC_SLAVE;
    end
  end

  // In slave mode the bit clock comes from the far end, so ticks are withheld.
  always_comb begin
    next_rate_active = (mode != MODE_SYNC_SLAVE); // [R4]
    next_sync_mode   = sync_mode;
  end

  always_ff @(posedge ref_clk_in) begin
    if (any_reset) begin
      rate_active_out <= 1'h0;
      sync_mode_out   <= 1'h0;
    end else begin
      rate_active_out <= next_rate_active;
      sync_mode_out   <= next_sync_mode;
    end
  end

  // One prescaler and one timer for both modes; only the modulus changes.
  assign modulus = sync_mode ? SYNC_PRESCALE : ASYNC_PRESCALE; // [R2] [R5]

  rate_prescaler u_prescaler (
    .ref_clk_in (ref_clk_in),
    .rst_in     (any_reset),
    .clear_in   (divisor_write), // [R6]
    .modulus_in (modulus),
    .step_out   (step)
  );

  // Down-counting timer reloaded from the divisor at each period end.
  assign timer_expired = step && (bit_rate_timer == 8'h00);

  always_comb begin
    next_bit_rate_timer = bit_rate_timer;
    next_tick           = 1'h0;
    if (divisor_write) begin
      next_bit_rate_timer = 8'h00; // [R6]
    end else if (timer_expired) begin
      next_bit_rate_timer = baud_divisor; // [R1] [R8]
      next_tick           = next_rate_active; // [R8] [R4]
    end else if (step) begin
      next_bit_rate_timer = bit_rate_timer - 8'h01; // [R1]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (any_reset) begin
      bit_rate_timer <= 8'h00;
      tick_out       <= 1'h0;
    end else begin
      bit_rate_timer <= next_bit_rate_timer;
      tick_out       <= next_tick;
    end
  end

endmodule : usart_baud_rate_generator
`default_nettype wire

// file: tb/baud_chk.sv
`timescale 1ns/1ps
`default_nettype none
module baud_chk import baud_gen_pkg::*; (
  input wire logic       ref_clk_in, rst_in, power_on_in, write_in, read_in,
  input wire logic [7:0] addr_in, wdata_in, rdata_out,
  input wire logic       tick_out, rate_active_out, sync_mode_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in || power_on_in);
  wire logic dw = write_in && addr_in == BAUD_DIVISOR_ADDR;
  a_tick_gap: assert property (tick_out |=> !tick_out[*3]) else $error("gap");
  a_async_gap: assert property (tick_out && !sync_mode_out |=> !tick_out[*8]) else $error("rate");
  a_rdata_idle: assert property (!$past(read_in) |-> rdata_out == 8'h00) else $error("idle");
  a_div_read: assert property (dw ##1 (read_in && addr_in == BAUD_DIVISOR_ADDR) |=> rdata_out == $past(wdata_in, 2))
    else $error("read");
  a_write_clear: assert property (dw |=> !tick_out[*4]) else $error("clear");
  a_slave_quiet: assert property (!rate_active_out && !$past(rate_active_out) |-> !tick_out) else $error("slave");
  a_first_async: assert property (dw && !sync_mode_out |-> ##66 tick_out) else $error("async");
  a_first_sync: assert property (dw && sync_mode_out && rate_active_out |-> ##6 tick_out) else $error("sync");
  c_tick: cover property (tick_out);
  c_write: cover property (dw);
  c_slave: cover property (sync_mode_out && !rate_active_out);
endmodule : baud_chk
bind usart_baud_rate_generator baud_chk chk (.*);
`default_nettype wire

// file: tb/bit_pacer.sv
`timescale 1ns/1ps
`default_nettype none
module bit_pacer (
  input  wire logic ref_clk_in, rst_in, tick_in, active_in,
  output int        bits_out
);
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) bits_out <= 0;
    else if (tick_in && active_in) bits_out <= bits_out + 1;
  end
endmodule : bit_pacer
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import baud_gen_pkg::*;;
  logic ref_clk_in = 1'h0, rst_in = 1'h1, power_on_in = 1'h1, write_in = 1'h0, read_in = 1'h0;
  logic tick_out, rate_active_out, sync_mode_out, e;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, v, s = 8'h12;
  int mismatches, comparisons, bits;
  always #2 ref_clk_in = ~ref_clk_in;
  usart_baud_rate_generator uut (
    .ref_clk_in      (ref_clk_in),
    .rst_in          (rst_in),
    .power_on_in     (power_on_in),
    .addr_in         (addr_in),
    .wdata_in        (wdata_in),
    .write_in        (write_in),
    .read_in         (read_in),
    .rdata_out       (rdata_out),
    .tick_out        (tick_out),
    .rate_active_out (rate_active_out),
    .sync_mode_out   (sync_mode_out)
  );
  bit_pacer partner (.ref_clk_in, .rst_in, .tick_in(tick_out), .active_in(rate_active_out), .bits_out(bits));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [7:0] x, g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk_in) {write_in, addr_in, wdata_in} <= {1'h1, a, d};
    @(posedge ref_clk_in) write_in <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in) {read_in, addr_in} <= {1'h1, a};
    @(posedge ref_clk_in) read_in <= 1'h0;
    #1 v = rdata_out;
  endtask : rd
  task automatic run(input logic [7:0] m, x);
    int f, p, n, k = 0;
    f = m[4] ? 4 : 64;
    p = f * (x + 1);
    wr(TX_STATUS_CONTROL_ADDR, m);
    rd(TX_STATUS_CONTROL_ADDR);
    chk("tx_status_control", m, v);
    chk("rate_active", {7'h00, (!m[4] || m[7])}, {7'h00, rate_active_out});
    chk("sync_mode", {7'h00, m[4]}, {7'h00, sync_mode_out});
    wr(BAUD_DIVISOR_ADDR, x);
    n = bits;
    for (int t = 1; t <= f + 2 * p + 32; t++) begin
      @(posedge ref_clk_in) #1 e = (!m[4] || m[7]) && t > f && (t - f - 1) % p == 0;
      k += e;
      chk("tick", {7'h00, e}, {7'h00, tick_out});
    end
    chk("bits", 8'(k), 8'(bits - n));
  endtask : run
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(posedge ref_clk_in);
    {rst_in, power_on_in} <= 2'h0;
    rd(BAUD_DIVISOR_ADDR);
    chk("div", BAUD_DIVISOR_POWER_ON, v);
    rd(8'h20);
    chk("free", 8'h00, v);
    for (int i = 0; i < 6; i++) begin
      s = lfsr(s);
      run(i % 3 == 0 ? 8'h00 : i % 3 == 1 ? 8'h90 : 8'h10, i == 4 ? 8'hff : i == 0 ? 8'h00 : s & 8'h0f);
    end
    wr(BAUD_DIVISOR_ADDR, s);
    rd(BAUD_DIVISOR_ADDR);
    chk("baud_divisor", s, v);
    @(posedge ref_clk_in) rst_in <= 1'h1;
    @(posedge ref_clk_in) rst_in <= 1'h0;
    #1 chk("reset_active", 8'h00, {7'h00, rate_active_out});
    rd(BAUD_DIVISOR_ADDR);
    chk("kept", s, v);
    complete_run();
  end
endmodule : tb
`default_nettype wire
